// ### inc/synth_cfg_pkg.sv
// Constants and types for the synthesizer configuration register bank.
// Assumes a byte-wide register port with seven address bits, one byte per address.
package synth_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 7;
  localparam logic [6:0]  FIRST_ADDR    = 7'h64;
  localparam logic [6:0]  LAST_ADDR     = 7'h79;
  localparam int          NUM_BYTES     = 22;
  localparam int          IDX_W         = 5;

  localparam logic [6:0]  SYNTH2_RATIO_OFS  = 7'h64;
  localparam logic [6:0]  SYNTH3_BASE_OFS   = 7'h68;
  localparam logic [6:0]  SYNTH3_MULT_OFS   = 7'h6a;
  localparam logic [6:0]  SYNTH3_RATIO_OFS  = 7'h6c;
  localparam logic [6:0]  LOOP_SOURCE_OFS   = 7'h70;
  localparam logic [6:0]  OUTPUT_GATES_OFS  = 7'h71;
  localparam logic [6:0]  LOCK_CRIT_OFS     = 7'h72;
  localparam logic [6:0]  CENTER_TRIM_OFS   = 7'h73;
  localparam logic [6:0]  FILTER_CHOICE_OFS = 7'h77;
  localparam logic [6:0]  PHASE_ADV0_OFS    = 7'h78;
  localparam logic [6:0]  PHASE_ADV1_OFS    = 7'h79;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] BASE_RATE_RESET   = 16'h9c40;
  localparam logic [15:0] MULTIPLIER_RESET  = 16'h0798;
  localparam logic [31:0] RATIO_RESET       = 32'h0001_0001;
  localparam logic [7:0]  LOOP_SOURCE_RESET = 8'he4;
  localparam logic [7:0]  GATES_RESET       = 8'h03;
  localparam logic [7:0]  LOCK_CRIT_RESET   = 8'haa;
  localparam logic [31:0] TRIM_RESET        = 32'h046a_aaab;
  localparam logic [7:0]  BYTE_ZERO         = 8'h00;
  localparam logic [7:0]  FILTER_MASK       = 8'h03;

  // Byte image, lowest address in the low lane; multi-byte registers big-endian
  localparam logic [NUM_BYTES*8-1:0] RESET_IMAGE = {
    BYTE_ZERO, BYTE_ZERO, BYTE_ZERO, TRIM_RESET[7:0], TRIM_RESET[15:8], TRIM_RESET[23:16],
    TRIM_RESET[31:24], LOCK_CRIT_RESET, GATES_RESET,
    LOOP_SOURCE_RESET, RATIO_RESET[7:0], RATIO_RESET[15:8], RATIO_RESET[23:16],
    RATIO_RESET[31:24], MULTIPLIER_RESET[7:0], MULTIPLIER_RESET[15:8],
    BASE_RATE_RESET[7:0], BASE_RATE_RESET[15:8], RATIO_RESET[7:0],
    RATIO_RESET[15:8], RATIO_RESET[23:16], RATIO_RESET[31:24]};
  localparam logic [NUM_BYTES*8-1:0] WRITE_MASK = {{2{8'hff}}, FILTER_MASK, {19{8'hff}}};

  // Bit offset of a byte address inside the flat image
  function automatic int lane(input logic [6:0] addr);
    return (int'(addr) - int'(FIRST_ADDR)) * 8;
  endfunction : lane

  // ----------------------------------------------------------------
  // Decoded configuration handed to the synthesis section
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]      synthesizer2_numerator_field;
    logic [15:0]      synthesizer2_denominator_field;
    logic [15:0]      synthesizer3_base_rate_field;
    logic [15:0]      synthesizer3_multiplier_field;
    logic [15:0]      synthesizer3_numerator_field;
    logic [15:0]      synthesizer3_denominator_field;
    logic [3:0][1:0]  loop_source_select;
    logic [3:0]       synth_output_gate;
    logic [3:0][1:0]  lock_criterion;
    logic [31:0]      center_rate_trim;
    logic [1:0]       loop_filter_choice;
    logic [7:0]       phase_advance_0;
    logic [7:0]       phase_advance_1;
  } synth_config_type;

endpackage : synth_cfg_pkg

// ### rtl/synth_config_registers.sv
// Configuration register bank for synthesizers: rates, sources, gates, trim, phase.
// Assumes the serial host port has already been turned into single-cycle byte
// write and read strobes with a seven-bit address, all synchronous to i_mclk.
`timescale 1ns/1ps
module synth_config_registers
  import synth_cfg_pkg::*;
(
  input  wire logic               i_mclk,
  input  wire logic               i_rst_b,
  input  wire logic               i_wr_en,
  input  wire logic               i_rd_en,
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [7:0]         i_wdata,
  output logic      [7:0]         o_rdata,
  output synth_config_type        o_cfg,
  output logic      [3:0]         o_lock_code_reserved
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic                     in_range;
  logic [IDX_W-1:0]         byte_idx;
  logic [NUM_BYTES*8-1:0]   image;
  logic [7:0]               regs_q [NUM_BYTES];
  logic [7:0]               rdata_d;
  logic [7:0]               rdata_q;

  // Addresses outside the bank are ignored on write and read as zero
  assign in_range = (i_addr >= FIRST_ADDR) && (i_addr <= LAST_ADDR);
  assign byte_idx = IDX_W'(i_addr - FIRST_ADDR);

  // ----------------------------------------------------------------
  // Byte storage
  // ----------------------------------------------------------------
  // One byte per address so multi-byte registers sit on consecutive addresses
  for (genvar k = 0; k < NUM_BYTES; k++) begin : g_byte
    logic hit;
    assign hit = i_wr_en && in_range && (byte_idx == IDX_W'(k));
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        regs_q[k] <= RESET_IMAGE[8*k +: 8];
      end else if (hit) begin
        regs_q[k] <= i_wdata & WRITE_MASK[8*k +: 8];
      end
    end
    assign image[8*k +: 8] = regs_q[k];
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data is registered; it holds until the next read strobe
  assign rdata_d = in_range ? regs_q[byte_idx] : 8'h00;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_q <= 8'h00;
    end else if (i_rd_en) begin
      rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Ratio and rate fields feed the rate product base*mult*8*num/den downstream
  assign o_cfg.synthesizer2_numerator_field   =
    {image[lane(SYNTH2_RATIO_OFS) +: 8], image[lane(SYNTH2_RATIO_OFS + 7'h01) +: 8]};
  assign o_cfg.synthesizer2_denominator_field =
    {image[lane(SYNTH2_RATIO_OFS + 7'h02) +: 8], image[lane(SYNTH2_RATIO_OFS + 7'h03) +: 8]};
  assign o_cfg.synthesizer3_base_rate_field   =
    {image[lane(SYNTH3_BASE_OFS) +: 8], image[lane(SYNTH3_BASE_OFS + 7'h01) +: 8]};
  assign o_cfg.synthesizer3_multiplier_field  =
    {image[lane(SYNTH3_MULT_OFS) +: 8], image[lane(SYNTH3_MULT_OFS + 7'h01) +: 8]};
  assign o_cfg.synthesizer3_numerator_field   =
    {image[lane(SYNTH3_RATIO_OFS) +: 8], image[lane(SYNTH3_RATIO_OFS + 7'h01) +: 8]};
  assign o_cfg.synthesizer3_denominator_field =
    {image[lane(SYNTH3_RATIO_OFS + 7'h02) +: 8], image[lane(SYNTH3_RATIO_OFS + 7'h03) +: 8]};

  // Bits 7:4 of the gate byte are stored for read-back but drive nothing
  assign o_cfg.synth_output_gate  = image[lane(OUTPUT_GATES_OFS) +: 4];
  assign o_cfg.center_rate_trim   =
    {image[lane(CENTER_TRIM_OFS) +: 8], image[lane(CENTER_TRIM_OFS + 7'h01) +: 8],
     image[lane(CENTER_TRIM_OFS + 7'h02) +: 8], image[lane(CENTER_TRIM_OFS + 7'h03) +: 8]};
  assign o_cfg.loop_filter_choice = image[lane(FILTER_CHOICE_OFS) +: 2];
  assign o_cfg.phase_advance_0    = image[lane(PHASE_ADV0_OFS) +: 8];
  assign o_cfg.phase_advance_1    = image[lane(PHASE_ADV1_OFS) +: 8];

  // Per-loop selectors; a reserved lock code is flagged so the monitor can hold off
  for (genvar n = 0; n < 4; n++) begin : g_loop
    assign o_cfg.loop_source_select[n] = image[lane(LOOP_SOURCE_OFS) + 2*n +: 2];
    assign o_cfg.lock_criterion[n]     = image[lane(LOCK_CRIT_OFS) + 2*n +: 2];
    assign o_lock_code_reserved[n]     = (o_cfg.lock_criterion[n] == 2'b00);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic trim_written_q;

  // Remembers whether software has touched the trim since reset
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trim_written_q <= 1'b0;
    end else if (i_wr_en && (i_addr >= CENTER_TRIM_OFS) && (i_addr < FILTER_CHOICE_OFS)) begin
      trim_written_q <= 1'b1;
    end
  end

  chk_ratio_layout: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH3_RATIO_OFS + 7'h03 |=>
      o_cfg.synthesizer3_denominator_field[7:0] == $past(i_wdata))
    else $error("ratio denominator low byte not taken");

  chk_source_field: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == LOOP_SOURCE_OFS |=> o_cfg.loop_source_select[3] == $past(i_wdata[7:6]))
    else $error("loop source selector 3 wrong");

  chk_gate_bits: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == OUTPUT_GATES_OFS |=> o_cfg.synth_output_gate == $past(i_wdata[3:0]))
    else $error("output gates wrong");

  chk_lock_field: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == LOCK_CRIT_OFS && i_wdata[1:0] == 2'b00 |=> o_lock_code_reserved[0])
    else $error("reserved lock code not flagged");

  chk_trim_bytes: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == CENTER_TRIM_OFS |=> o_cfg.center_rate_trim[31:24] == $past(i_wdata))
    else $error("trim high byte wrong");

  chk_trim_reset: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !trim_written_q |-> o_cfg.center_rate_trim == TRIM_RESET)
    else $error("trim default lost");

  chk_filter_mask: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_rd_en && i_addr == FILTER_CHOICE_OFS |=> o_rdata[7:2] == 6'h00)
    else $error("filter reserved bits not zero");

  chk_phase_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == PHASE_ADV0_OFS ##1 !i_wr_en [*2] |-> o_cfg.phase_advance_0 == $past(i_wdata, 2))
    else $error("phase advance not held");

  chk_read_back: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && in_range && i_addr != FILTER_CHOICE_OFS ##1
      (i_rd_en && !i_wr_en && i_addr == $past(i_addr)) |=> o_rdata == $past(i_wdata, 2))
    else $error("read-back mismatch");

  // Byte placement of the remaining multi-byte fields and bit placement of the single-byte fields; a swapped lane shows up here
  chk_syn2_numer: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH2_RATIO_OFS |=>
      o_cfg.synthesizer2_numerator_field[15:8] == $past(i_wdata))
    else $error("synth 2 numerator high byte wrong");

  chk_syn2_denom: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH2_RATIO_OFS + 7'h03 |=>
      o_cfg.synthesizer2_denominator_field[7:0] == $past(i_wdata))
    else $error("synth 2 denominator low byte wrong");

  chk_syn3_numer: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH3_RATIO_OFS |=>
      o_cfg.synthesizer3_numerator_field[15:8] == $past(i_wdata))
    else $error("synth 3 numerator high byte wrong");

  chk_base_high: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH3_BASE_OFS |=>
      o_cfg.synthesizer3_base_rate_field[15:8] == $past(i_wdata))
    else $error("base rate high byte wrong");

  chk_base_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH3_BASE_OFS + 7'h01 |=>
      o_cfg.synthesizer3_base_rate_field[7:0] == $past(i_wdata))
    else $error("base rate low byte wrong");

  chk_mult_high: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == SYNTH3_MULT_OFS |=>
      o_cfg.synthesizer3_multiplier_field[15:8] == $past(i_wdata))
    else $error("multiplier high byte wrong");

  chk_source_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == LOOP_SOURCE_OFS |=>
      o_cfg.loop_source_select[0] == $past(i_wdata[1:0]))
    else $error("loop source selector 0 wrong");

  chk_lock_codes: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == LOCK_CRIT_OFS |=> o_cfg.lock_criterion == $past(i_wdata))
    else $error("lock criterion fields wrong");

  chk_lock_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == LOCK_CRIT_OFS && i_wdata[7:6] != 2'b00 |=> !o_lock_code_reserved[3])
    else $error("valid lock code flagged reserved");

  chk_trim_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == CENTER_TRIM_OFS + 7'h03 |=>
      o_cfg.center_rate_trim[7:0] == $past(i_wdata))
    else $error("trim low byte wrong");

  chk_filter_bits: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == FILTER_CHOICE_OFS |=> o_cfg.loop_filter_choice == $past(i_wdata[1:0]))
    else $error("filter choice wrong");

  chk_phase_one: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && i_addr == PHASE_ADV1_OFS |=> o_cfg.phase_advance_1 == $past(i_wdata))
    else $error("phase advance 1 wrong");

  // Unmapped traffic must leave the bank alone and read as zero; read data holds without a read strobe
  chk_unmapped_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_wr_en && !in_range |=> $stable(o_cfg))
    else $error("unmapped write changed a field");

  chk_unmapped_read: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_rd_en && !in_range |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  chk_rdata_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_rd_en |=> $stable(o_rdata))
    else $error("read data moved without a read");

endmodule : synth_config_registers

// ### tb/tb.sv
// Self-checking bench for the synthesizer configuration register bank.
// Assumes the byte strobe port of the bank; the bench drives it directly.
`timescale 1ns/1ps
module tb
  import synth_cfg_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------------------------------
  logic              i_mclk  = 1'b0;
  logic              i_rst_b = 1'b0;
  logic              i_wr_en = 1'b0;
  logic              i_rd_en = 1'b0;
  logic [ADDR_W-1:0] i_addr  = 7'h00;
  logic [7:0]        i_wdata = 8'h00;
  logic [7:0]        o_rdata;
  synth_config_type  o_cfg;
  logic [3:0]        o_lock_code_reserved;
  int                fails   = 0;
  int                checked = 0;
  logic [7:0]        p [NUM_BYTES];
  // Power-up byte image, lowest address first
  logic [7:0] dflt [NUM_BYTES] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h9c, 8'h40, 8'h07, 8'h98,
    8'h00, 8'h01, 8'h00, 8'h01, 8'he4, 8'h03, 8'haa, 8'h04, 8'h6a, 8'haa, 8'hab, 8'h00,
    8'h00, 8'h00};

  // 40 MHz master clock
  always #12.5 i_mclk = ~i_mclk;

  synth_config_registers u_synth_config_registers (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_cfg(o_cfg),
    .o_lock_code_reserved(o_lock_code_reserved));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle strobes; outputs are sampled 1 ns after the taking edge
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr_en <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    @(posedge i_mclk);
    i_rd_en <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every byte reads its default, trim compensates the master clock
  task automatic defaults_scn;
    logic [7:0] b;
    for (int i = 0; i < NUM_BYTES; i++) begin
      rd(FIRST_ADDR + 7'(i), b);
      check(b, dflt[i]);
    end
    check(o_cfg.center_rate_trim, 32'h046a_aaab);
    check(o_lock_code_reserved, 4'h0);
  endtask : defaults_scn

  // Distinct pattern in every byte except trim bytes 15 to 17, which share 8'hfa; fields must land in the right halves
  task automatic fields_scn;
    logic [7:0] b;
    for (int i = 0; i < NUM_BYTES; i++) begin
      p[i] = 8'(i * 37 + 5);
    end
    // Software limits: supported base code, gate bits 7:4 at default, trim inside 5 percent
    p[4]  = 8'h30;
    p[5]  = 8'hd4;
    p[13] = p[13] & 8'h0f;
    {p[15], p[16], p[17], p[18]} = 32'hfafa_fafb;
    for (int i = 0; i < NUM_BYTES; i++) begin
      wr(FIRST_ADDR + 7'(i), p[i]);
    end
    check(o_cfg, {p[0], p[1], p[2], p[3], p[4], p[5], p[6], p[7], p[8], p[9], p[10], p[11],
      p[12], p[13][3:0], p[14], p[15], p[16], p[17], p[18], p[19][1:0], p[20],
      p[21]});
    for (int i = 0; i < NUM_BYTES; i++) begin
      rd(FIRST_ADDR + 7'(i), b);
      check(b, (i == 19) ? (p[i] & 8'h03) : p[i]);
    end
    // Synthesizer 2 back to unscaled operation: its numerator and denominator return to one
    for (int i = 0; i < 4; i++) begin
      wr(SYNTH2_RATIO_OFS + 7'(i), 8'(i % 2));
    end
    check({o_cfg.synthesizer2_numerator_field, o_cfg.synthesizer2_denominator_field},
      32'h0001_0001);
  endtask : fields_scn

  // All four lock codes in every field, then a mixed byte
  task automatic lock_scn;
    for (int c = 0; c < 4; c++) begin
      wr(LOCK_CRIT_OFS, {4{2'(c)}});
      check(o_cfg.lock_criterion, {4{2'(c)}});
      check(o_lock_code_reserved, (c == 0) ? 4'hf : 4'h0);
    end
    wr(LOCK_CRIT_OFS, 8'h1b);
    check(o_lock_code_reserved, 4'h8);
  endtask : lock_scn

  // Writes outside the map change nothing and reads there give zero
  task automatic unmapped_scn;
    synth_config_type keep;
    logic [7:0]       b;
    keep = o_cfg;
    wr(7'h63, 8'hff);
    wr(7'h7a, 8'hff);
    check(o_cfg, keep);
    rd(7'h63, b);
    check(b, 8'h00);
    rd(7'h7a, b);
    check(b, 8'h00);
  endtask : unmapped_scn

  // Read straight after a write to the same byte, then let the phase value rest
  task automatic back_to_back_scn;
    @(posedge i_mclk);
    i_wr_en <= 1'b1;
    i_addr  <= PHASE_ADV0_OFS;
    i_wdata <= 8'h5a;
    @(posedge i_mclk);
    i_wr_en <= 1'b0;
    i_rd_en <= 1'b1;
    @(posedge i_mclk);
    i_rd_en <= 1'b0;
    #1;
    check(o_rdata, 8'h5a);
    repeat (2) @(posedge i_mclk);
    #1;
    check(o_cfg.phase_advance_0, 8'h5a);
  endtask : back_to_back_scn

  // ----------------------------------------------------------------
  // Main sequence, with a second reset in mid-run
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    defaults_scn();
    fields_scn();
    lock_scn();
    unmapped_scn();
    back_to_back_scn();
    @(posedge i_mclk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    defaults_scn();
    tally_and_finish();
  end
endmodule : tb
